// file: rtl/tacr_top.sv
// Alert and control register bank of the temperature sensor.
// Assumes the bus engine presents decoded byte accesses, command pulses and error pulses on CLK.
`timescale 1ns/1ps
module tacr_top (
    // Clock and reset.
    input  wire logic                 CLK,
    input  wire logic                 RESET,
    // Register access from the bus engine.
    input  wire tacr_pkg::tacr_req_t  REQ,
    output logic [7:0]                RDATA,
    // Bus mode and common commands.
    input  wire logic                 I3C_MODE,
    input  wire logic                 CMD_ENEC_ERR,
    input  wire logic                 CMD_DISEC_ERR,
    input  wire logic                 CMD_RSTDAA,
    input  wire logic                 BUS_RESET,
    // Error events from the bus engine.
    input  wire tacr_pkg::tacr_err_t  ERR_EVENT,
    // Conversion engine.
    output logic                      CONV_START,
    input  wire logic                 CONV_DONE,
    input  wire logic [15:0]          CONV_RESULT,
    output logic                      SENSOR_ACTIVE,
    // Alert.
    output logic                      IBI_REQ,
    output logic [7:0]                EVENT_STATUS
);
    logic [7:0]            sens_cfg_q;
    logic [3:0]            int_en_q;
    logic                  err_en_q;
    logic [7:0]            hlim_lo_q;
    logic [7:0]            hlim_hi_q;
    logic [7:0]            llim_lo_q;
    logic [7:0]            llim_hi_q;
    logic [7:0]            chlim_lo_q;
    logic [7:0]            chlim_hi_q;
    logic [3:0]            temp_q;
    logic [1:0]            err_q;
    logic [7:0]            evt_q;
    logic [7:0]            rdata_d;
    logic [7:0]            rdata_q;
    logic [3:0]            temp_set;
    logic [3:0]            temp_clr;
    logic [1:0]            err_set;
    logic [1:0]            err_clr;
    logic                  gclr;
    logic                  wr_err_clr;
    tacr_pkg::tacr_temp_t  hit;
    tacr_pkg::tacr_conv_t  conv_q;

    function automatic logic wr_at(input logic [7:0] a);
        wr_at = REQ.wr && (REQ.addr == a);
    endfunction

    // The request fields stand in the expressions so that a change of any of them re-evaluates the strobe.
    assign gclr       = REQ.wr && (REQ.addr == tacr_pkg::TACR_ADDR_INT_CFG)
                        && REQ.wdata[tacr_pkg::TACR_BIT_GCLR];
    assign wr_err_clr = REQ.wr && (REQ.addr == tacr_pkg::TACR_ADDR_ERR_CLR) && I3C_MODE;

    // Sensor configuration; only bit 0 is writable.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sens_cfg_q <= tacr_pkg::TACR_RST_SENS_CFG;
        end else if (wr_at(tacr_pkg::TACR_ADDR_SENS_CFG)) begin
            sens_cfg_q <= {7'h00, REQ.wdata[tacr_pkg::TACR_BIT_SENS_DIS]};
        end
    end

    // Temperature interrupt enables, bits 3 to 0.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            int_en_q <= tacr_pkg::TACR_RST_INT_CFG[3:0];
        end else if (wr_at(tacr_pkg::TACR_ADDR_INT_CFG)) begin
            int_en_q <= REQ.wdata[3:0] & tacr_pkg::TACR_MASK_INT_CFG[3:0];
        end
    end

    // Error interrupt enable follows only the common commands and bus reset.
    always_ff @(posedge CLK) begin
        if (RESET || BUS_RESET || CMD_RSTDAA) begin
            err_en_q <= tacr_pkg::TACR_RST_INT_CFG[tacr_pkg::TACR_BIT_ERR_EN];
        end else if (CMD_ENEC_ERR) begin
            err_en_q <= 1'b1;
        end else if (CMD_DISEC_ERR) begin
            err_en_q <= 1'b0;
        end
    end

    // Limit bytes; masked bits never store a one.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            hlim_lo_q  <= tacr_pkg::TACR_RST_HLIM_LO;
            hlim_hi_q  <= tacr_pkg::TACR_RST_HLIM_HI;
            llim_lo_q  <= tacr_pkg::TACR_RST_LLIM_LO;
            llim_hi_q  <= tacr_pkg::TACR_RST_LLIM_HI;
            chlim_lo_q <= tacr_pkg::TACR_RST_CHLIM_LO;
            chlim_hi_q <= tacr_pkg::TACR_RST_CHLIM_HI;
        end else if (REQ.wr) begin
            case (REQ.addr)
                tacr_pkg::TACR_ADDR_HLIM_LO: begin
                    hlim_lo_q <= REQ.wdata & tacr_pkg::TACR_MASK_LIM_LO;
                end
                tacr_pkg::TACR_ADDR_HLIM_HI: begin
                    hlim_hi_q <= REQ.wdata & tacr_pkg::TACR_MASK_LIM_HI;
                end
                tacr_pkg::TACR_ADDR_LLIM_LO: begin
                    llim_lo_q <= REQ.wdata & tacr_pkg::TACR_MASK_LIM_LO;
                end
                tacr_pkg::TACR_ADDR_LLIM_HI: begin
                    llim_hi_q <= REQ.wdata & tacr_pkg::TACR_MASK_LIM_HI;
                end
                tacr_pkg::TACR_ADDR_CHLIM_LO: begin
                    chlim_lo_q <= REQ.wdata & tacr_pkg::TACR_MASK_LIM_LO;
                end
                tacr_pkg::TACR_ADDR_CHLIM_HI: begin
                    chlim_hi_q <= REQ.wdata & tacr_pkg::TACR_MASK_LIM_HI;
                end
                default: begin
                end
            endcase
        end
    end

    // Conversion sequencer: a running conversion always completes.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            conv_q <= tacr_pkg::TACR_IDLE;
        end else begin
            case (conv_q)
                tacr_pkg::TACR_IDLE: begin
                    conv_q <= sens_cfg_q[0] ? tacr_pkg::TACR_HALT : tacr_pkg::TACR_CONV;
                end
                tacr_pkg::TACR_CONV: begin
                    if (CONV_DONE) begin
                        conv_q <= sens_cfg_q[0] ? tacr_pkg::TACR_HALT : tacr_pkg::TACR_IDLE;
                    end
                end
                tacr_pkg::TACR_HALT: begin
                    if (!sens_cfg_q[0]) begin
                        conv_q <= tacr_pkg::TACR_IDLE;
                    end
                end
                default: begin
                    conv_q <= tacr_pkg::TACR_IDLE;
                end
            endcase
        end
    end

    assign CONV_START    = (conv_q == tacr_pkg::TACR_IDLE) && !sens_cfg_q[0];
    assign SENSOR_ACTIVE = (conv_q != tacr_pkg::TACR_HALT);

    tacr_cmp u_cmp (
        .result   (CONV_RESULT),
        .high_lim ({hlim_hi_q, hlim_lo_q}),
        .low_lim  ({llim_hi_q, llim_lo_q}),
        .crit_lim ({chlim_hi_q, chlim_lo_q}),
        .hit      (hit)
    );

    // Temperature flags are evaluated only at the end of a conversion; error flags on any error event.
    assign temp_set = (conv_q == tacr_pkg::TACR_CONV && CONV_DONE) ? hit : 4'h0;
    assign temp_clr = {4{gclr}};
    assign err_set  = {ERR_EVENT.pec, ERR_EVENT.par};
    assign err_clr  = {gclr || (wr_err_clr && REQ.wdata[tacr_pkg::TACR_BIT_PEC_CLR]),
                       gclr || (wr_err_clr && REQ.wdata[tacr_pkg::TACR_BIT_PAR_CLR])};

    tacr_sticky #(.W(4)) u_temp (
        .clk    (CLK),
        .rst    (RESET),
        .set    (temp_set),
        .clr    (temp_clr),
        .flag_q (temp_q)
    );

    tacr_sticky #(.W(2)) u_err (
        .clk    (CLK),
        .rst    (RESET),
        .set    (err_set),
        .clr    (err_clr),
        .flag_q (err_q)
    );

    // Event status collects pending interrupt sources; bit 0 temperature, bit 1 error.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            evt_q <= 8'h00;
        end else begin
            evt_q[0] <= (evt_q[0] && !gclr) || |(temp_set & int_en_q);
            evt_q[1] <= (evt_q[1] && !gclr) || (|err_set && err_en_q);
            evt_q[7:2] <= 6'h00;
        end
    end

    assign IBI_REQ      = |(temp_q & int_en_q) || (|err_q && err_en_q);
    assign EVENT_STATUS = evt_q;

    // Read mux; command registers read as zero.
    always_comb begin
        rdata_d = 8'h00;
        case (REQ.addr)
            tacr_pkg::TACR_ADDR_SENS_CFG:  rdata_d = sens_cfg_q;
            tacr_pkg::TACR_ADDR_INT_CFG:   rdata_d = {3'h0, err_en_q, int_en_q};
            tacr_pkg::TACR_ADDR_HLIM_LO:   rdata_d = hlim_lo_q;
            tacr_pkg::TACR_ADDR_HLIM_HI:   rdata_d = hlim_hi_q;
            tacr_pkg::TACR_ADDR_LLIM_LO:   rdata_d = llim_lo_q;
            tacr_pkg::TACR_ADDR_LLIM_HI:   rdata_d = llim_hi_q;
            tacr_pkg::TACR_ADDR_CHLIM_LO:  rdata_d = chlim_lo_q;
            tacr_pkg::TACR_ADDR_CHLIM_HI:  rdata_d = chlim_hi_q;
            tacr_pkg::TACR_ADDR_EVT_STS:   rdata_d = evt_q;
            tacr_pkg::TACR_ADDR_TMP_STS:   rdata_d = {4'h0, temp_q};
            tacr_pkg::TACR_ADDR_ERR_STS:   rdata_d = {6'h00, err_q};
            default:                       rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rdata_q <= 8'h00;
        end else if (REQ.rd) begin
            rdata_q <= rdata_d;
        end
    end

    assign RDATA = rdata_q;
endmodule

// file: rtl/tacr_pkg.sv
// Constants and carrier types for the temperature alert configuration register bank.
// Assumes a byte-wide register port driven by the serial bus engine on the same clock.
// Operation
// - Write one bit1 clears packet-check fault
// - Write one bit0 clears parity fault
// - Error clear register acts only in I3C
// - Log bad checksum or write parity errors
// - Sensor disable bit stops conversions
// - Running conversion finishes before sensor halts
// - Global clear wipes event, temperature, error status
// - Error enable gates interrupt on logged errors
// - Error enable changes only by commands, reset
// - Direct writes never alter error enable
// - Bit3 enables critical-low interrupt
// - Bit2 enables critical-high interrupt
// - Bit1 enables low-temperature interrupt
// - Bit0 enables high-temperature interrupt
// - Result above high limit sets high flag
// - Read-only zero limit bits ignore writes
// - High limit low byte resets to 70h
// - Result above critical-high sets critical-high flag
// - Result below low limit sets critical-low flag
package tacr_pkg;

    localparam logic [7:0] TACR_ADDR_ERR_CLR  = 8'h14;
    localparam logic [7:0] TACR_ADDR_SENS_CFG = 8'h1A;
    localparam logic [7:0] TACR_ADDR_INT_CFG  = 8'h1B;
    localparam logic [7:0] TACR_ADDR_HLIM_LO  = 8'h1C;
    localparam logic [7:0] TACR_ADDR_HLIM_HI  = 8'h1D;
    localparam logic [7:0] TACR_ADDR_LLIM_LO  = 8'h1E;
    localparam logic [7:0] TACR_ADDR_LLIM_HI  = 8'h1F;
    localparam logic [7:0] TACR_ADDR_CHLIM_LO = 8'h20;
    localparam logic [7:0] TACR_ADDR_CHLIM_HI = 8'h21;
    localparam logic [7:0] TACR_ADDR_EVT_STS  = 8'h30;
    localparam logic [7:0] TACR_ADDR_TMP_STS  = 8'h33;
    localparam logic [7:0] TACR_ADDR_ERR_STS  = 8'h34;

    localparam logic [7:0] TACR_RST_SENS_CFG  = 8'h00;
    localparam logic [7:0] TACR_RST_INT_CFG   = 8'h00;
    localparam logic [7:0] TACR_RST_HLIM_LO   = 8'h70;
    localparam logic [7:0] TACR_RST_HLIM_HI   = 8'h03;
    localparam logic [7:0] TACR_RST_LLIM_LO   = 8'h00;
    localparam logic [7:0] TACR_RST_LLIM_HI   = 8'h00;
    localparam logic [7:0] TACR_RST_CHLIM_LO  = 8'h50;
    localparam logic [7:0] TACR_RST_CHLIM_HI  = 8'h05;

    // Writable masks of the limit bytes; the rest read as zero.
    localparam logic [7:0] TACR_MASK_LIM_LO   = 8'hFC;
    localparam logic [7:0] TACR_MASK_LIM_HI   = 8'h1F;
    // Writable bits of the interrupt configuration (bit 4 excluded).
    localparam logic [7:0] TACR_MASK_INT_CFG  = 8'h0F;

    localparam int TACR_BIT_PAR_CLR  = 0;
    localparam int TACR_BIT_PEC_CLR  = 1;
    localparam int TACR_BIT_SENS_DIS = 0;
    localparam int TACR_BIT_GCLR     = 7;
    localparam int TACR_BIT_ERR_EN   = 4;

    localparam int TACR_N_TEMP = 4;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tacr_req_t;

    typedef struct packed {
        logic crit_low;
        logic crit_high;
        logic low;
        logic high;
    } tacr_temp_t;

    typedef struct packed {
        logic pec;
        logic par;
    } tacr_err_t;

    typedef enum logic [1:0] {
        TACR_IDLE = 2'b00,
        TACR_CONV = 2'b01,
        TACR_HALT = 2'b11
    } tacr_conv_t;

endpackage

// file: rtl/tacr_cmp.sv
// Limit comparator: four threshold tests of a signed result.
// Assumes limits and result share one two's complement 16-bit format.
`timescale 1ns/1ps
module tacr_cmp (
    // Operands.
    input  wire logic [15:0]        result,
    input  wire logic [15:0]        high_lim,
    input  wire logic [15:0]        low_lim,
    input  wire logic [15:0]        crit_lim,
    // Tests.
    output tacr_pkg::tacr_temp_t    hit
);
    always_comb begin
        hit.high      = $signed(result) > $signed(high_lim);
        hit.crit_high = $signed(result) > $signed(crit_lim);
        hit.crit_low  = $signed(result) < $signed(low_lim);
        hit.low       = $signed(result) < $signed(low_lim);
    end
endmodule

// file: rtl/tacr_sticky.sv
// Sticky status bits (W of them): set pulses win over clear pulses.
// Assumes one-cycle set and clear pulses on the register clock.
`timescale 1ns/1ps
module tacr_sticky #(
    parameter int W = 4
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst,
    // Events.
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    // State.
    output logic      [W-1:0] flag_q
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    flag_q[i] <= 1'b0;
                end else if (set[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (clr[i]) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

// file: dv/tacr_asserts.sv
// Checker of the alert register bank, watching the top ports only.
// Assumes it is bound into tacr_top on the single clock CLK.
`timescale 1ns/1ps
module tacr_asserts (
    // Clock and reset.
    input wire logic                CLK,
    input wire logic                RESET,
    // Watched ports.
    input wire tacr_pkg::tacr_req_t REQ,
    input wire logic [7:0]          RDATA,
    input wire logic                I3C_MODE,
    input wire logic                CMD_ENEC_ERR,
    input wire logic                CMD_DISEC_ERR,
    input wire logic                CMD_RSTDAA,
    input wire logic                BUS_RESET,
    input wire tacr_pkg::tacr_err_t ERR_EVENT,
    input wire logic                CONV_START,
    input wire logic                CONV_DONE,
    input wire logic                SENSOR_ACTIVE,
    input wire logic                IBI_REQ
);
    wire no_clr = !CMD_DISEC_ERR && !CMD_RSTDAA && !BUS_RESET;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_rdata_reset: assert property (disable iff (1'b0) RESET |=> RDATA == 8'h00)
        else $error("read data not cleared");
    a_rdata_stands: assert property (!$past(REQ.rd) |-> $stable(RDATA))
        else $error("read data moved without a read");
    a_cmd_reads: assert property (REQ.rd && REQ.addr == 8'h14 |=> RDATA == 8'h00)
        else $error("clear command read nonzero");
    a_start_once: assert property (CONV_START && !$past(RESET) |=> !CONV_START)
        else $error("start held after being taken");
    a_halt_start: assert property (!SENSOR_ACTIVE |-> !CONV_START)
        else $error("start while halted");
    a_dis_write: assert property (REQ.wr && REQ.addr == 8'h1A && REQ.wdata[0] |=> !CONV_START)
        else $error("start after disable");
    a_ibi_cause: assert property ($rose(IBI_REQ) |-> $past(CONV_DONE || ERR_EVENT != 2'b00 || CMD_ENEC_ERR || REQ.wr))
        else $error("interrupt without cause");
    a_gclr_ibi: assert property (REQ.wr && REQ.addr == 8'h1B && REQ.wdata[7] && !CONV_DONE && ERR_EVENT == 2'b00 |=> !IBI_REQ)
        else $error("interrupt after global clear");
    a_err_ibi: assert property (CMD_ENEC_ERR ##1 no_clr ##1 (ERR_EVENT != 2'b00 && no_clr) |=> IBI_REQ)
        else $error("enabled error gave no interrupt");
    a_err_mode: assert property (!I3C_MODE && REQ.wr && REQ.addr == 8'h14 && no_clr |=> !$fell(IBI_REQ))
        else $error("error clear acted outside I3C");
endmodule
bind tacr_top tacr_asserts tacr_asserts_i (.CLK(CLK), .RESET(RESET), .REQ(REQ), .RDATA(RDATA), .I3C_MODE(I3C_MODE),
    .CMD_ENEC_ERR(CMD_ENEC_ERR), .CMD_DISEC_ERR(CMD_DISEC_ERR), .CMD_RSTDAA(CMD_RSTDAA), .BUS_RESET(BUS_RESET),
    .ERR_EVENT(ERR_EVENT), .CONV_START(CONV_START), .CONV_DONE(CONV_DONE), .SENSOR_ACTIVE(SENSOR_ACTIVE),
    .IBI_REQ(IBI_REQ));

// file: dv/tacr_conv_model.sv
// Conversion engine model: one result per taken start, after a fixed delay.
// Assumes start is a level sampled on the rising clock edge.
`timescale 1ns/1ps
module tacr_conv_model #(
    parameter int DLY = 20
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Engine handshake.
    input  wire logic        start,
    input  wire logic [15:0] value,
    output logic             busy,
    output logic             done,
    output logic [15:0]      result
);
    int cnt;
    // Outside the done pulse the result bus carries junk, never the value.
    assign result = done ? value : ~value;
    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (rst) begin
            busy <= 1'b0;
        end else if (busy) begin
            cnt <= cnt - 1;
            if (cnt == 0) begin
                busy <= 1'b0;
                done <= 1'b1;
            end
        end else if (start) begin
            busy <= 1'b1;
            cnt <= DLY;
        end
    end
endmodule

// file: dv/test_tacr_top.sv
// Self-checking bench of the alert register bank.
// Assumes the package, the design and the engine model are compiled first.
`timescale 1ns/1ps
module test_tacr_top;
    logic                CLK = 1'b0;
    logic                RESET = 1'b1;
    tacr_pkg::tacr_req_t req = '0;
    tacr_pkg::tacr_err_t err_ev = '0;
    logic [3:0]          cmds = 4'h0;
    logic                i3c = 1'b1;
    logic [15:0]         val = 16'h0100;
    logic [15:0]         res;
    logic [7:0]          rdata;
    logic [7:0]          evt;
    logic                start, done, busy, active, ibi;
    int                  err_total = 0;
    int                  total_checks = 0;
    always #2.5 CLK = ~CLK;
    tacr_top tacr_top_i (.CLK(CLK), .RESET(RESET), .REQ(req), .RDATA(rdata), .I3C_MODE(i3c), .CMD_ENEC_ERR(cmds[0]),
        .CMD_DISEC_ERR(cmds[1]), .CMD_RSTDAA(cmds[2]), .BUS_RESET(cmds[3]), .ERR_EVENT(err_ev), .CONV_START(start),
        .CONV_DONE(done), .CONV_RESULT(res), .SENSOR_ACTIVE(active), .IBI_REQ(ibi), .EVENT_STATUS(evt));
    tacr_conv_model tacr_conv_model_i (.clk(CLK), .rst(RESET), .start(start), .value(val), .busy(busy),
        .done(done), .result(res));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        req = '{1'b1, 1'b0, a, d};
        @(negedge CLK);
        req = '0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge CLK);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge CLK);
        req = '0;
        @(negedge CLK);
        chk(rdata, exp);
    endtask
    task automatic pcmd(input logic [3:0] c);
        @(negedge CLK);
        cmds = c;
        @(negedge CLK);
        cmds = 4'h0;
    endtask
    task automatic perr(input logic [1:0] e);
        @(negedge CLK);
        err_ev = e;
        @(negedge CLK);
        err_ev = '0;
    endtask
    // Waits for the given number of completed conversions, then lets the flags land.
    task automatic wdone(input int c);
        int n;
        for (int k = 0; k < c; k++) begin
            n = 0;
            @(negedge CLK);
            while (done !== 1'b1 && n < 100) begin
                @(negedge CLK);
                n++;
            end
            chk(16'(n < 100), 16'h0001);
        end
        @(negedge CLK);
    endtask
    task automatic t_reset();
        logic [7:0] ad [10] = '{8'h14, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h40};
        logic [7:0] ex [10] = '{8'h00, 8'h00, 8'h00, 8'h70, 8'h03, 8'h00, 8'h00, 8'h50, 8'h05, 8'h00};
        for (int i = 0; i < 10; i++) begin
            rchk(ad[i], ex[i]);
        end
        wr(8'h1C, 8'hFF);
        rchk(8'h1C, 8'hFC);
        wr(8'h1D, 8'hE3);
        rchk(8'h1D, 8'h03);
        wr(8'h21, 8'hE5);
        rchk(8'h21, 8'h05);
        wr(8'h1C, 8'h70);
        wr(8'h1D, 8'h03);
    endtask
    task automatic t_err();
        wr(8'h1B, 8'h10);
        rchk(8'h1B, 8'h00);
        pcmd(4'h1);
        perr(2'b01);
        chk(ibi, 1'b1);
        chk(evt, 8'h02);
        rchk(8'h30, 8'h02);
        rchk(8'h1B, 8'h10);
        rchk(8'h34, 8'h01);
        i3c = 1'b0;
        wr(8'h14, 8'h01);
        rchk(8'h34, 8'h01);
        i3c = 1'b1;
        perr(2'b10);
        wr(8'h14, 8'h01);
        rchk(8'h34, 8'h02);
        wr(8'h14, 8'h02);
        rchk(8'h34, 8'h00);
        pcmd(4'h2);
        rchk(8'h1B, 8'h00);
        perr(2'b11);
        chk(ibi, 1'b0);
        wr(8'h1B, 8'h80);
        rchk(8'h34, 8'h00);
        chk(evt, 8'h00);
        pcmd(4'h1);
        pcmd(4'h4);
        rchk(8'h1B, 8'h00);
        pcmd(4'h1);
        pcmd(4'h8);
        rchk(8'h1B, 8'h00);
    endtask
    task automatic t_temp();
        val = 16'h0370;
        wdone(2);
        rchk(8'h33, 8'h00);
        val = 16'h0371;
        wdone(2);
        rchk(8'h33, 8'h01);
        chk(ibi, 1'b0);
        chk(evt, 8'h00);
        wr(8'h1B, 8'h01);
        chk(ibi, 1'b1);
        val = 16'h0600;
        wdone(2);
        wr(8'h1B, 8'h04);
        chk(ibi, 1'b1);
        val = 16'h0100;
        wdone(2);
        rchk(8'h33, 8'h05);
        rchk(8'h30, 8'h01);
        wr(8'h1B, 8'h0A);
        chk(ibi, 1'b0);
        wr(8'h1B, 8'h80);
        rchk(8'h33, 8'h00);
        chk(evt, 8'h00);
        val = 16'hFF00;
        wdone(2);
        rchk(8'h33, 8'h0A);
        wr(8'h1B, 8'h02);
        chk(ibi, 1'b1);
        wr(8'h1B, 8'h08);
        chk(ibi, 1'b1);
        val = 16'h0100;
        wdone(2);
        wr(8'h1B, 8'h85);
        chk(ibi, 1'b0);
    endtask
    task automatic t_halt();
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 100) begin
            @(negedge CLK);
            n++;
        end
        val = 16'h0371;
        wr(8'h1A, 8'h01);
        chk(active, 1'b1);
        wdone(1);
        rchk(8'h33, 8'h01);
        chk(evt, 8'h01);
        chk({active, start}, 2'b00);
        n = 0;
        repeat (40) begin
            @(negedge CLK);
            n += int'(done);
        end
        chk(16'(n), 16'h0000);
        wr(8'h1A, 8'h00);
        wdone(1);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        results();
    end
    initial begin
        repeat (8) @(negedge CLK);
        RESET = 1'b0;
        t_reset();
        t_err();
        t_temp();
        t_halt();
        results();
    end
endmodule
